// *** hbdh_pkg.sv ***
package hbdh_pkg;
    // ========================================
    // Handshake timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Bus acknowledge is released this long after negation
    localparam int unsigned ACK_RELEASE_NS = 16;
    localparam int unsigned ACK_RELEASE_CYC =
        (ACK_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Device drives read data at cycle start and delays this long before acknowledging
    localparam int unsigned ACK_DELAY_NS = 16;
    localparam int unsigned ACK_DELAY_CYC =
        (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SYNC_STAGES = 3;
    // Pin mode for the sync-detect / request-to-send pin
    typedef enum logic {
        HBDH_PIN_SYNC = 1'b0,
        HBDH_PIN_RTS = 1'b1
    } hbdh_pin_mode_e;
endpackage

// *** hbdh_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface hbdh_if;
    logic chip_select_n;
    logic intr_ack_in_n;
    logic read_not_write;
    logic [hbdh_pkg::DATA_W-1:0] host_data;
    logic [hbdh_pkg::DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic bus_ack_n_o;
    logic bus_ack_n_oe;
    logic tx_dma_request_n;
    logic tx_dma_ack_n;
    logic dma_cycle_done_n;
    logic transfer_end_dev_o;
    logic transfer_end_dev_oe;
    logic transfer_end_host_o;
    logic transfer_end_host_oe;
    logic bus_ack_n;
    logic transfer_end_n;
    // Pull-ups on the open-drain / three-state lines
    assign bus_ack_n = bus_ack_n_oe ? bus_ack_n_o : 1'b1;
    assign transfer_end_n = (transfer_end_dev_oe & ~transfer_end_dev_o)
        | (transfer_end_host_oe & ~transfer_end_host_o) ? 1'b0 : 1'b1;
    modport device (
        input chip_select_n, intr_ack_in_n, read_not_write, host_data,
        input tx_dma_ack_n, dma_cycle_done_n, transfer_end_n,
        output dev_data, dev_data_oe, bus_ack_n_o, bus_ack_n_oe,
        output tx_dma_request_n, transfer_end_dev_o, transfer_end_dev_oe
    );
    modport host (
        output chip_select_n, intr_ack_in_n, read_not_write, host_data,
        output tx_dma_ack_n, dma_cycle_done_n, transfer_end_host_o,
        output transfer_end_host_oe,
        input dev_data, dev_data_oe, bus_ack_n, tx_dma_request_n, transfer_end_n
    );
endinterface
`default_nettype wire

// *** hbdh_device.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbdh_device #(
    parameter int unsigned DATA_W = hbdh_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    hbdh_if.device bus,
    input wire logic full_duplex_dma,
    input wire logic tx_queue_full,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic last_rx_read,
    input wire logic tx_count_terminal,
    input wire logic pin_mode,
    input wire logic rts_assert,
    input wire logic sync_detected,
    input wire logic bit_tick,
    output logic [DATA_W-1:0] write_data,
    output logic write_strobe,
    output logic dma_write_strobe,
    output logic last_tx_load,
    output logic general_input_two_n,
    output logic modem_send_request_n,
    output logic read_strobe
);
    // ========================================
    // Input synchronisers
    localparam int unsigned NS = hbdh_pkg::SYNC_STAGES;
    logic [NS-1:0] s_cs, s_iack, s_dak, s_dtc, s_te;
    logic [NS-1:0] next_s_cs, next_s_iack, next_s_dak, next_s_dtc, next_s_te;
    logic cs_f, iack_f, dak_f, dtc_f, te_f;
    logic next_cs_f, next_iack_f, next_dak_f, next_dtc_f, next_te_f;
    always_comb begin
        next_s_cs = {s_cs[NS-2:0], bus.chip_select_n};
        next_s_iack = {s_iack[NS-2:0], bus.intr_ack_in_n};
        next_s_dak = {s_dak[NS-2:0], bus.tx_dma_ack_n};
        next_s_dtc = {s_dtc[NS-2:0], bus.dma_cycle_done_n};
        next_s_te = {s_te[NS-2:0], bus.transfer_end_n};
        next_cs_f = (s_cs[1] == s_cs[2]) ? s_cs[2] : cs_f;
        next_iack_f = (s_iack[1] == s_iack[2]) ? s_iack[2] : iack_f;
        next_dak_f = (s_dak[1] == s_dak[2]) ? s_dak[2] : dak_f;
        next_dtc_f = (s_dtc[1] == s_dtc[2]) ? s_dtc[2] : dtc_f;
        next_te_f = (s_te[1] == s_te[2]) ? s_te[2] : te_f;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_cs <= '1;
            s_iack <= '1;
            s_dak <= '1;
            s_dtc <= '1;
            s_te <= '1;
            cs_f <= 1'b1;
            iack_f <= 1'b1;
            dak_f <= 1'b1;
            dtc_f <= 1'b1;
            te_f <= 1'b1;
        end else begin
            s_cs <= next_s_cs;
            s_iack <= next_s_iack;
            s_dak <= next_s_dak;
            s_dtc <= next_s_dtc;
            s_te <= next_s_te;
            cs_f <= next_cs_f;
            iack_f <= next_iack_f;
            dak_f <= next_dak_f;
            dtc_f <= next_dtc_f;
            te_f <= next_te_f;
        end
    end

    // ========================================
    // Acknowledge state machine
    typedef enum logic [2:0] {
        HBDH_IDLE = 3'b000,
        HBDH_WAIT = 3'b001,
        HBDH_ACK = 3'b011,
        HBDH_NEG = 3'b010,
        HBDH_END = 3'b110
    } hbdh_state_e;
    hbdh_state_e state, next_state;
    logic [hbdh_pkg::CNT_W-1:0] cnt, next_cnt;
    logic is_dma, next_is_dma, is_read, next_is_read, captured, next_captured;
    logic ack_o, next_ack_o, ack_oe, next_ack_oe, data_oe, next_data_oe;
    logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
    logic wstb, next_wstb, dstb, next_dstb, rstb, next_rstb, last_ld, next_last_ld;
    logic cpu_start, dma_start, cpu_end, dma_end;
    always_comb begin
        cpu_start = !cs_f || !iack_f;
        dma_start = full_duplex_dma && !dak_f;
        cpu_end = cs_f && iack_f;
        dma_end = !dtc_f || dak_f;
        next_state = state;
        next_cnt = cnt;
        next_is_dma = is_dma;
        next_is_read = is_read;
        next_captured = captured;
        next_ack_o = ack_o;
        next_ack_oe = ack_oe;
        next_data_oe = data_oe;
        next_wdata = wdata;
        next_rdata = rdata;
        next_wstb = 1'b0;
        next_dstb = 1'b0;
        next_rstb = 1'b0;
        next_last_ld = last_ld;
        unique case (state)
            HBDH_IDLE: begin
                if (dma_start) begin
                    next_state = HBDH_WAIT;
                    next_is_dma = 1'b1;
                    next_is_read = 1'b0;
                    next_captured = 1'b0;
                    next_cnt = hbdh_pkg::CNT_ZERO;
                    next_last_ld = !te_f;
                end else if (cpu_start) begin
                    next_state = HBDH_WAIT;
                    next_is_dma = 1'b0;
                    next_is_read = bus.read_not_write || !iack_f;
                    next_captured = 1'b0;
                    next_cnt = hbdh_pkg::CNT_ZERO;
                    next_rdata = read_data;
                    next_data_oe = bus.read_not_write || !iack_f;
                    next_rstb = bus.read_not_write && !cs_f;
                end
            end
            HBDH_WAIT: begin
                next_cnt = cnt + hbdh_pkg::CNT_ONE;
                if (is_dma ? dma_end : cpu_end) begin
                    if (!is_read && !captured) begin
                        next_wdata = bus.host_data;
                        next_wstb = !is_dma;
                        next_dstb = is_dma;
                    end
                    next_state = HBDH_END;
                    next_data_oe = 1'b0;
                    next_cnt = hbdh_pkg::CNT_ZERO;
                end else if (32'(cnt) + 1 >= hbdh_pkg::ACK_DELAY_CYC) begin
                    if (!is_read) begin
                        next_wdata = bus.host_data;
                        next_captured = 1'b1;
                        next_wstb = !is_dma;
                        next_dstb = is_dma;
                    end
                    next_ack_o = 1'b0;
                    next_ack_oe = 1'b1;
                    next_state = HBDH_ACK;
                end
            end
            HBDH_ACK: begin
                if (is_dma ? dma_end : cpu_end) begin
                    next_ack_o = 1'b1;
                    next_data_oe = 1'b0;
                    next_cnt = hbdh_pkg::CNT_ZERO;
                    next_state = HBDH_NEG;
                end
            end
            HBDH_NEG: begin
                next_cnt = cnt + hbdh_pkg::CNT_ONE;
                if (32'(cnt) + 1 >= hbdh_pkg::ACK_RELEASE_CYC) begin
                    next_ack_oe = 1'b0;
                    next_state = HBDH_END;
                end
            end
            HBDH_END: begin
                next_last_ld = 1'b0;
                if (is_dma ? dak_f : cpu_end) begin
                    next_state = HBDH_IDLE;
                end
            end
            default: next_state = HBDH_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= HBDH_IDLE;
            cnt <= hbdh_pkg::CNT_ZERO;
            is_dma <= 1'b0;
            is_read <= 1'b0;
            captured <= 1'b0;
            ack_o <= 1'b1;
            ack_oe <= 1'b0;
            data_oe <= 1'b0;
            wdata <= '0;
            rdata <= '0;
            wstb <= 1'b0;
            dstb <= 1'b0;
            rstb <= 1'b0;
            last_ld <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            is_dma <= next_is_dma;
            is_read <= next_is_read;
            captured <= next_captured;
            ack_o <= next_ack_o;
            ack_oe <= next_ack_oe;
            data_oe <= next_data_oe;
            wdata <= next_wdata;
            rdata <= next_rdata;
            wstb <= next_wstb;
            dstb <= next_dstb;
            rstb <= next_rstb;
            last_ld <= next_last_ld;
        end
    end

    // ========================================
    // Pins and side signals
    logic te_drive, next_te_drive, sync_pend, next_sync_pend, sync_out, next_sync_out;
    logic gpi, next_gpi, rts, next_rts, txrq, next_txrq;
    always_comb begin
        next_te_drive = last_rx_read || tx_count_terminal;
        next_sync_pend = sync_pend;
        next_sync_out = sync_out;
        if (sync_detected) begin
            next_sync_pend = 1'b1;
            next_sync_out = 1'b1;
        end else if (sync_pend && bit_tick) begin
            next_sync_pend = 1'b0;
            next_sync_out = 1'b0;
        end
        next_gpi = full_duplex_dma ? 1'b1 : dak_f;
        next_rts = (pin_mode == hbdh_pkg::HBDH_PIN_RTS) ? !rts_assert : sync_out;
        next_txrq = !(full_duplex_dma && !tx_queue_full);
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            te_drive <= 1'b0;
            sync_pend <= 1'b0;
            sync_out <= 1'b1;
            gpi <= 1'b1;
            rts <= 1'b1;
            txrq <= 1'b1;
        end else begin
            te_drive <= next_te_drive;
            sync_pend <= next_sync_pend;
            sync_out <= next_sync_out;
            gpi <= next_gpi;
            rts <= next_rts;
            txrq <= next_txrq;
        end
    end
    assign bus.transfer_end_dev_o = 1'b0;
    assign bus.transfer_end_dev_oe = te_drive;
    assign bus.bus_ack_n_o = ack_o;
    assign bus.bus_ack_n_oe = ack_oe;
    assign bus.dev_data = rdata;
    assign bus.dev_data_oe = data_oe;
    assign bus.tx_dma_request_n = txrq;
    assign write_data = wdata;
    assign write_strobe = wstb;
    assign dma_write_strobe = dstb;
    assign read_strobe = rstb;
    assign last_tx_load = last_ld;
    assign general_input_two_n = gpi;
    assign modem_send_request_n = rts;
endmodule
`default_nettype wire

// *** hbdh_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbdh_host #(
    parameter int unsigned DATA_W = hbdh_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    hbdh_if.host bus,
    input wire logic req_valid,
    input wire logic req_dma,
    input wire logic req_read,
    input wire logic req_iack,
    input wire logic req_last,
    input wire logic [DATA_W-1:0] req_data,
    output logic req_ready,
    output logic [DATA_W-1:0] rsp_data,
    output logic rsp_valid,
    output logic tx_request_seen_n
);
    // ========================================
    // Acknowledge and transmit request synchronisers
    logic [hbdh_pkg::SYNC_STAGES-1:0] s_ack, next_s_ack;
    logic [hbdh_pkg::SYNC_STAGES-1:0] s_rq, next_s_rq;
    logic ack_f, next_ack_f, rq_f, next_rq_f;
    always_comb begin
        next_s_ack = {s_ack[1:0], bus.bus_ack_n};
        next_s_rq = {s_rq[1:0], bus.tx_dma_request_n};
        next_ack_f = (s_ack[1] == s_ack[2]) ? s_ack[2] : ack_f;
        next_rq_f = (s_rq[1] == s_rq[2]) ? s_rq[2] : rq_f;
    end
    // ========================================
    // Cycle sequencer
    typedef enum logic [1:0] {
        HBDH_H_IDLE = 2'b00,
        HBDH_H_WAIT = 2'b01,
        HBDH_H_DONE = 2'b11
    } hbdh_hstate_e;
    hbdh_hstate_e st, next_st;
    logic cs, next_cs, ia, next_ia, rw, next_rw, dak, next_dak, dtc, next_dtc;
    logic te, next_te, rv, next_rv;
    logic [DATA_W-1:0] hd, next_hd, rd, next_rd;
    always_comb begin
        next_st = st;
        next_cs = cs;
        next_ia = ia;
        next_rw = rw;
        next_dak = dak;
        next_dtc = dtc;
        next_te = te;
        next_hd = hd;
        next_rd = rd;
        next_rv = 1'b0;
        unique case (st)
            HBDH_H_IDLE: begin
                if (req_valid) begin
                    next_hd = req_data;
                    next_rw = req_read;
                    next_dak = !req_dma;
                    next_te = req_dma && req_last;
                    next_cs = !(!req_dma && !req_iack);
                    next_ia = !(!req_dma && req_iack);
                    next_st = HBDH_H_WAIT;
                end
            end
            HBDH_H_WAIT: begin
                if (!ack_f) begin
                    next_rd = bus.dev_data;
                    next_cs = 1'b1;
                    next_ia = 1'b1;
                    next_dtc = dak ? 1'b1 : 1'b0;
                    next_st = HBDH_H_DONE;
                end
            end
            HBDH_H_DONE: begin
                if (ack_f) begin
                    next_dak = 1'b1;
                    next_dtc = 1'b1;
                    next_te = 1'b0;
                    next_rv = 1'b1;
                    next_st = HBDH_H_IDLE;
                end
            end
            default: next_st = HBDH_H_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_ack <= '1;
            s_rq <= '1;
            ack_f <= 1'b1;
            rq_f <= 1'b1;
            st <= HBDH_H_IDLE;
            cs <= 1'b1;
            ia <= 1'b1;
            rw <= 1'b0;
            dak <= 1'b1;
            dtc <= 1'b1;
            te <= 1'b0;
            hd <= '0;
            rd <= '0;
            rv <= 1'b0;
        end else begin
            s_ack <= next_s_ack;
            s_rq <= next_s_rq;
            ack_f <= next_ack_f;
            rq_f <= next_rq_f;
            st <= next_st;
            cs <= next_cs;
            ia <= next_ia;
            rw <= next_rw;
            dak <= next_dak;
            dtc <= next_dtc;
            te <= next_te;
            hd <= next_hd;
            rd <= next_rd;
            rv <= next_rv;
        end
    end
    assign bus.chip_select_n = cs;
    assign bus.intr_ack_in_n = ia;
    assign bus.read_not_write = rw;
    assign bus.host_data = hd;
    assign bus.tx_dma_ack_n = dak;
    assign bus.dma_cycle_done_n = dtc;
    assign bus.transfer_end_host_o = 1'b0;
    assign bus.transfer_end_host_oe = te;
    assign req_ready = (st == HBDH_H_IDLE);
    assign rsp_data = rd;
    assign rsp_valid = rv;
    assign tx_request_seen_n = rq_f;
endmodule
`default_nettype wire

// *** hbdh_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbdh_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chip_select_n,
    input wire logic intr_ack_in_n,
    input wire logic read_not_write,
    input wire logic tx_dma_ack_n,
    input wire logic dma_cycle_done_n,
    input wire logic dev_data_oe,
    input wire logic bus_ack_n_o,
    input wire logic bus_ack_n_oe,
    input wire logic bus_ack_n,
    input wire logic transfer_end_dev_o,
    input wire logic transfer_end_dev_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ========================================
    // Acknowledge handshake and transfer end
    ack_drive_a: assert property (!bus_ack_n_o |-> bus_ack_n_oe)
        else $error("acknowledge low while not driven");
    ack_wait_a: assert property ($fell(chip_select_n) |-> bus_ack_n [*3])
        else $error("acknowledge before select was filtered");
    ack_start_a: assert property ($fell(chip_select_n) |-> ##[1:12] !bus_ack_n)
        else $error("no acknowledge for host cycle");
    dma_ack_start_a: assert property ($fell(tx_dma_ack_n) |-> ##[1:12] !bus_ack_n)
        else $error("no acknowledge for dma load cycle");
    ack_hold_a: assert property ($fell(bus_ack_n) |-> !bus_ack_n [*3])
        else $error("acknowledge dropped too early");
    ack_negate_a: assert property (
        $rose(chip_select_n & intr_ack_in_n) |-> ##[1:8] bus_ack_n)
        else $error("acknowledge not negated after cycle end");
    dma_negate_a: assert property (
        $fell(dma_cycle_done_n) || $rose(tx_dma_ack_n) |-> ##[1:8] bus_ack_n)
        else $error("acknowledge not negated after dma end");
    ack_float_a: assert property ($rose(bus_ack_n_o) |-> ##[1:4] !bus_ack_n_oe)
        else $error("acknowledge not released");
    read_drive_a: assert property (
        !bus_ack_n && (!chip_select_n && read_not_write || !intr_ack_in_n) |-> dev_data_oe)
        else $error("read acknowledged without data driven");
    done_drain_a: assert property (transfer_end_dev_oe |-> !transfer_end_dev_o)
        else $error("transfer end driven high");
endmodule
`default_nettype wire

// *** host_bus_dma_handshake_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module host_bus_dma_handshake_bench;
    typedef struct {logic rd; logic dma; logic last; logic [7:0] data;} hbdh_note_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic full_duplex_dma = 1'b0, tx_queue_full = 1'b0, last_rx_read = 1'b0;
    logic tx_count_terminal = 1'b0, pin_mode = 1'b0, rts_assert = 1'b0;
    logic sync_detected = 1'b0, bit_tick = 1'b0;
    logic [7:0] read_data = 8'h00, req_data = 8'h00, write_data, rsp_data;
    logic req_valid = 1'b0, req_dma = 1'b0, req_read = 1'b0, req_iack = 1'b0;
    logic req_last = 1'b0;
    logic write_strobe, dma_write_strobe, last_tx_load, general_input_two_n;
    logic modem_send_request_n, read_strobe, req_ready, rsp_valid, tx_request_seen_n;
    logic last_seen = 1'b0;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] wr_q[$];
    hbdh_note_s done_q[$];
    hbdh_note_s nt;
    logic [7:0] wexp;
    logic rs_q[$];
    always #4 clk = ~clk;
    hbdh_if bus_if();
    hbdh_device i_hbdh_device (.clk(clk), .nrst(nrst), .bus(bus_if.device),
        .full_duplex_dma(full_duplex_dma), .tx_queue_full(tx_queue_full),
        .read_data(read_data), .last_rx_read(last_rx_read),
        .tx_count_terminal(tx_count_terminal), .pin_mode(pin_mode),
        .rts_assert(rts_assert), .sync_detected(sync_detected), .bit_tick(bit_tick),
        .write_data(write_data), .write_strobe(write_strobe),
        .dma_write_strobe(dma_write_strobe), .last_tx_load(last_tx_load),
        .general_input_two_n(general_input_two_n),
        .modem_send_request_n(modem_send_request_n), .read_strobe(read_strobe));
    hbdh_host i_hbdh_host (.clk(clk), .nrst(nrst), .bus(bus_if.host),
        .req_valid(req_valid), .req_dma(req_dma), .req_read(req_read),
        .req_iack(req_iack), .req_last(req_last), .req_data(req_data),
        .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .tx_request_seen_n(tx_request_seen_n));
    hbdh_sva i_hbdh_sva (.clk(clk), .nrst(nrst), .chip_select_n(bus_if.chip_select_n),
        .intr_ack_in_n(bus_if.intr_ack_in_n), .read_not_write(bus_if.read_not_write),
        .tx_dma_ack_n(bus_if.tx_dma_ack_n), .dma_cycle_done_n(bus_if.dma_cycle_done_n),
        .dev_data_oe(bus_if.dev_data_oe), .bus_ack_n_o(bus_if.bus_ack_n_o),
        .bus_ack_n_oe(bus_if.bus_ack_n_oe), .bus_ack_n(bus_if.bus_ack_n),
        .transfer_end_dev_o(bus_if.transfer_end_dev_o),
        .transfer_end_dev_oe(bus_if.transfer_end_dev_oe));
    // ========================================
    // Result monitor
    always @(posedge clk) begin
        if (last_tx_load === 1'b1) begin
            last_seen = 1'b1;
        end
        if (write_strobe === 1'b1 || dma_write_strobe === 1'b1) begin
            if (wr_q.size() == 0) begin
                `CHK("write_pending", 1'b1, 1'b0);
            end else begin
                wexp = wr_q.pop_front();
                `CHK("write_data", wexp, write_data);
            end
        end
        if (read_strobe === 1'b1) begin
            if (rs_q.size() == 0) begin
                `CHK("read_pending", 1'b1, 1'b0);
            end else begin
                `CHK("read_strobe", rs_q.pop_front(), read_strobe);
            end
        end
        if (rsp_valid === 1'b1) begin
            if (done_q.size() == 0) begin
                `CHK("cycle_pending", 1'b1, 1'b0);
            end else begin
                nt = done_q.pop_front();
                if (nt.rd) begin
                    `CHK("rsp_data", nt.data, rsp_data);
                end
                if (nt.dma) begin
                    `CHK("last_tx_load", nt.last, last_seen);
                end
                last_seen = 1'b0;
            end
        end
    end
    // ========================================
    // Tasks
    task automatic op(input logic dma, input logic rd, input logic iack, input logic last);
        logic [7:0] d;
        int n;
        d = 8'($urandom);
        if (rd | iack) read_data = d;
        else wr_q.push_back(d);
        done_q.push_back('{rd | iack, dma, last, d});
        if (rd) rs_q.push_back(1'b1);
        req_dma = dma;
        req_read = rd;
        req_iack = iack;
        req_last = last;
        req_data = d;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while ((done_q.size() != 0 || wr_q.size() != 0 || rs_q.size() != 0) && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("cycle_done", 1'b1, n < 100);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ========================================
    // Tests
    initial begin
        void'($urandom(4));
        step(12);
        nrst = 1'b1;
        step(1);
        for (int i = 0; i < 6; i++) begin
            op(1'b0, i % 3 == 1, i % 3 == 2, 1'b0);
        end
        $display("Test cpu cycles done");
        full_duplex_dma = 1'b1;
        step(4);
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 1'b0, i == 3);
            `CHK("general_input_two_n", 1'b1, general_input_two_n);
        end
        // Leave full-duplex DMA mid-cycle so the held-low acknowledge reads back
        fork
            op(1'b1, 1'b0, 1'b0, 1'b0);
            begin
                step(8);
                full_duplex_dma = 1'b0;
                step(2);
                `CHK("general_input_low", 1'b0, general_input_two_n);
                full_duplex_dma = 1'b1;
            end
        join
        $display("Test dma loads done");
        for (int i = 0; i < 4; i++) begin
            full_duplex_dma = i[1];
            tx_queue_full = i[0];
            step(8);
            `CHK("tx_dma_request_n", ~(i[1] & ~i[0]), bus_if.tx_dma_request_n);
            `CHK("tx_request_seen_n", ~(i[1] & ~i[0]), tx_request_seen_n);
        end
        $display("Test transmit request done");
        for (int i = 0; i < 2; i++) begin
            last_rx_read = (i == 0);
            tx_count_terminal = (i == 1);
            step(2);
            `CHK("transfer_end_n", 1'b0, bus_if.transfer_end_n);
            last_rx_read = 1'b0;
            tx_count_terminal = 1'b0;
            step(3);
            `CHK("transfer_end_n", 1'b1, bus_if.transfer_end_n);
        end
        $display("Test transfer end done");
        pin_mode = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rts_assert = i[0];
            step(2);
            `CHK("modem_send_request_n", ~i[0], modem_send_request_n);
        end
        pin_mode = 1'b0;
        step(2);
        sync_detected = 1'b1;
        step(1);
        sync_detected = 1'b0;
        step(1);
        `CHK("sync_before_tick", 1'b1, modem_send_request_n);
        bit_tick = 1'b1;
        step(1);
        bit_tick = 1'b0;
        step(1);
        `CHK("sync_after_tick", 1'b0, modem_send_request_n);
        $display("Test pin modes done");
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
